// *** logic/awsc_defines.svh ***
// Offsets, field positions, reset values and response codes for the area wait block
`ifndef AWSC_DEFINES_SVH
`define AWSC_DEFINES_SVH

`define AWSC_OFF_WAIT      12'h000
`define AWSC_OFF_CTRL      12'h004
`define AWSC_OFF_STAT      12'h008

`define AWSC_WAIT_RESET    16'hFFFF
`define AWSC_CTRL_RESET    3'h0

`define AWSC_A6_HI         15
`define AWSC_A6_LO         13
`define AWSC_A5_HI         12
`define AWSC_A5_LO         10
`define AWSC_A4_HI         9
`define AWSC_A4_LO         7
`define AWSC_A3_HI         6
`define AWSC_A3_LO         5
`define AWSC_A2_HI         4
`define AWSC_A2_LO         3
`define AWSC_A0_HI         2
`define AWSC_A0_LO         0

`define AWSC_CTRL_SAMPLE   0
`define AWSC_CTRL_A2_SDRAM 1
`define AWSC_CTRL_A3_SDRAM 2

`define AWSC_RESP_OKAY     2'h0
`define AWSC_RESP_SLVERR   2'h2

`endif

// *** logic/awsc_pkg.sv ***
// Types shared by the area wait block
package awsc_pkg;
  typedef enum logic [1:0] {
    ST_IDLE,
    ST_FIRST,
    ST_BURST
  } awsc_state_t;

  typedef logic [2:0] awsc_area_t;
endpackage

// *** logic/awsc_top.sv ***
// Area wait-state configuration register with wait engine and AXI4-Lite slave
`include "awsc_defines.svh"
`timescale 1ns/100ps
`default_nettype none

module awsc_top #(
  parameter int ADDR_W = 12
) (
  input  wire logic              aclk,
  input  wire logic              aresetn,
  input  wire logic              ce,
  input  wire logic              manual_rst_n,
  input  wire logic              standby,
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic [2:0]        s_axi_awprot,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic [2:0]        s_axi_arprot,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  input  wire logic              acc_valid,
  output logic                   acc_ready,
  input  wire awsc_pkg::awsc_area_t acc_area,
  input  wire logic [2:0]        acc_extra_beats,
  input  wire logic              wait_req_n,
  output logic                   bus_clock_output,
  output logic                   beat_done,
  output logic                   acc_done,
  output logic [1:0]             cas_latency
);
  import awsc_pkg::*;

  // Register group
  logic [15:0]       area_wait_state_control;
  logic [15:0]       next_area_wait_state_control;
  logic [2:0]        ctrl;
  logic [2:0]        next_ctrl;

  // AXI group
  logic              aw_held;
  logic              next_aw_held;
  logic [ADDR_W-1:0] aw_addr;
  logic [ADDR_W-1:0] next_aw_addr;
  logic              w_held;
  logic              next_w_held;
  logic [31:0]       w_data;
  logic [31:0]       next_w_data;
  logic [3:0]        w_strb;
  logic [3:0]        next_w_strb;
  logic              bvalid_q;
  logic              next_bvalid_q;
  logic [1:0]        bresp_q;
  logic [1:0]        next_bresp_q;
  logic              rvalid_q;
  logic              next_rvalid_q;
  logic [31:0]       rdata_q;
  logic [31:0]       next_rdata_q;
  logic [1:0]        rresp_q;
  logic [1:0]        next_rresp_q;

  // Pin and clock group
  logic              wait_meta;
  logic              wait_sync;
  logic              wait_held;
  logic              next_wait_held;
  logic              bclk_q;
  logic              next_bclk_q;

  // Engine group
  awsc_state_t       state;
  awsc_state_t       next_state;
  awsc_area_t        cur_area;
  awsc_area_t        next_cur_area;
  logic [3:0]        cnt;
  logic [3:0]        next_cnt;
  logic [2:0]        beats_left;
  logic [2:0]        next_beats_left;
  logic              honour;
  logic              next_honour;
  logic              beat_q;
  logic              next_beat_q;
  logic              done_q;
  logic              next_done_q;

  logic              wr_fire;
  logic              rd_fire;
  logic [31:0]       wr_mask;
  logic [3:0]        first_waits;
  logic              first_honour;
  logic [3:0]        burst_load;
  logic              is_burst_area;
  logic              stall;
  logic [ADDR_W-1:0] wr_addr;
  logic [31:0]       wr_data;
  logic [3:0]        wr_strb;
  awsc_area_t        sel_area;

  function automatic logic [3:0] waits3(input logic [2:0] code);
    case (code)
      3'd4:    waits3 = 4'd4;
      3'd5:    waits3 = 4'd6;
      3'd6:    waits3 = 4'd8;
      3'd7:    waits3 = 4'd10;
      default: waits3 = {1'b0, code};
    endcase
  endfunction

  function automatic logic [3:0] pitch3(input logic [2:0] code);
    case (code)
      3'd0:    pitch3 = 4'd2;
      3'd1:    pitch3 = 4'd2;
      3'd2:    pitch3 = 4'd3;
      3'd3:    pitch3 = 4'd4;
      3'd4:    pitch3 = 4'd4;
      3'd5:    pitch3 = 4'd6;
      3'd6:    pitch3 = 4'd8;
      default: pitch3 = 4'd10;
    endcase
  endfunction

  function automatic logic [1:0] cas2(input logic [1:0] code);
    cas2 = (code == 2'd0) ? 2'd1 : code;
  endfunction

  // AXI slave
  assign s_axi_awready = ~aw_held & ~bvalid_q;
  assign s_axi_wready  = ~w_held & ~bvalid_q;
  assign s_axi_arready = ~rvalid_q;
  assign s_axi_bvalid  = bvalid_q;
  assign s_axi_bresp   = bresp_q;
  assign s_axi_rvalid  = rvalid_q;
  assign s_axi_rdata   = rdata_q;
  assign s_axi_rresp   = rresp_q;

  // Either half may be held or arriving now; no path through next_ values
  assign wr_addr = aw_held ? aw_addr : s_axi_awaddr;
  assign wr_data = w_held ? w_data : s_axi_wdata;
  assign wr_strb = w_held ? w_strb : s_axi_wstrb;
  assign wr_fire = (aw_held | (s_axi_awvalid & s_axi_awready))
                 & (w_held | (s_axi_wvalid & s_axi_wready)) & ~bvalid_q;
  assign rd_fire = s_axi_arvalid & ~rvalid_q;

  generate
    for (genvar i = 0; i < 4; i++) begin : g_mask
      assign wr_mask[8*i +: 8] = {8{wr_strb[i]}};
    end
  endgenerate

  always_comb begin
    next_aw_held  = aw_held;
    next_aw_addr  = aw_addr;
    next_w_held   = w_held;
    next_w_data   = w_data;
    next_w_strb   = w_strb;
    next_bvalid_q = bvalid_q;
    next_bresp_q  = bresp_q;
    next_rvalid_q = rvalid_q;
    next_rdata_q  = rdata_q;
    next_rresp_q  = rresp_q;
    if (s_axi_awvalid && s_axi_awready) begin
      next_aw_held = 1'b1;
      next_aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      next_w_held = 1'b1;
      next_w_data = s_axi_wdata;
      next_w_strb = s_axi_wstrb;
    end
    if (wr_fire) begin
      next_aw_held  = 1'b0;
      next_w_held   = 1'b0;
      next_bvalid_q = 1'b1;
      if (wr_addr == `AWSC_OFF_WAIT || wr_addr == `AWSC_OFF_CTRL
          || wr_addr == `AWSC_OFF_STAT) begin
        next_bresp_q = `AWSC_RESP_OKAY;
      end else begin
        next_bresp_q = `AWSC_RESP_SLVERR;
      end
    end else if (bvalid_q && s_axi_bready) begin
      next_bvalid_q = 1'b0;
    end
    if (rd_fire) begin
      next_rvalid_q = 1'b1;
      next_rresp_q  = `AWSC_RESP_OKAY;
      if (s_axi_araddr == `AWSC_OFF_WAIT) begin
        next_rdata_q = {16'h0000, area_wait_state_control};
      end else if (s_axi_araddr == `AWSC_OFF_CTRL) begin
        next_rdata_q = {29'h0000_0000, ctrl};
      end else if (s_axi_araddr == `AWSC_OFF_STAT) begin
        next_rdata_q = {24'h00_0000, wait_held, cur_area, cnt};
      end else begin
        next_rdata_q = 32'h0000_0000;
        next_rresp_q = `AWSC_RESP_SLVERR;
      end
    end else if (rvalid_q && s_axi_rready) begin
      next_rvalid_q = 1'b0;
    end
  end

  // Register file: only power-on reset touches it
  always_comb begin
    next_area_wait_state_control = area_wait_state_control;
    next_ctrl                    = ctrl;
    if (wr_fire && wr_addr == `AWSC_OFF_WAIT) begin
      next_area_wait_state_control = (area_wait_state_control & ~wr_mask[15:0])
                                   | (wr_data[15:0] & wr_mask[15:0]);
    end else if (wr_fire && wr_addr == `AWSC_OFF_CTRL) begin
      next_ctrl = (ctrl & ~wr_mask[2:0]) | (wr_data[2:0] & wr_mask[2:0]);
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      area_wait_state_control <= `AWSC_WAIT_RESET;
      ctrl                    <= `AWSC_CTRL_RESET;
      aw_held                 <= 1'b0;
      aw_addr                 <= '0;
      w_held                  <= 1'b0;
      w_data                  <= 32'h0000_0000;
      w_strb                  <= 4'h0;
      bvalid_q                <= 1'b0;
      bresp_q                 <= `AWSC_RESP_OKAY;
      rvalid_q                <= 1'b0;
      rdata_q                 <= 32'h0000_0000;
      rresp_q                 <= `AWSC_RESP_OKAY;
    end else if (ce) begin
      area_wait_state_control <= next_area_wait_state_control;
      ctrl                    <= next_ctrl;
      aw_held                 <= next_aw_held;
      aw_addr                 <= next_aw_addr;
      w_held                  <= next_w_held;
      w_data                  <= next_w_data;
      w_strb                  <= next_w_strb;
      bvalid_q                <= next_bvalid_q;
      bresp_q                 <= next_bresp_q;
      rvalid_q                <= next_rvalid_q;
      rdata_q                 <= next_rdata_q;
      rresp_q                 <= next_rresp_q;
    end
  end

  // Bus clock output and wait pin sampling
  assign bus_clock_output = bclk_q;

  always_comb begin
    next_bclk_q    = standby ? 1'b0 : ~bclk_q;
    next_wait_held = wait_held;
    if (!ctrl[`AWSC_CTRL_SAMPLE]) begin
      next_wait_held = ~wait_sync;
    end else if (bclk_q) begin
      next_wait_held = ~wait_sync;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wait_meta <= 1'b1;
      wait_sync <= 1'b1;
      wait_held <= 1'b0;
      bclk_q    <= 1'b0;
    end else if (ce) begin
      wait_meta <= wait_req_n;
      wait_sync <= wait_meta;
      wait_held <= next_wait_held;
      bclk_q    <= next_bclk_q;
    end
  end

  // Settings follow the running access; in ST_IDLE they follow the acc_area request pins
  assign sel_area = (state == ST_IDLE) ? acc_area : cur_area;

  // First-cycle settings per area
  always_comb begin
    first_waits   = 4'd0;
    first_honour  = 1'b0;
    burst_load    = 4'd0;
    is_burst_area = 1'b0;
    cas_latency   = 2'd0;
    case (sel_area)
      3'd6: begin
        first_waits   = waits3(area_wait_state_control[`AWSC_A6_HI:`AWSC_A6_LO]);
        is_burst_area = 1'b1;
      end
      3'd5: begin
        first_waits   = waits3(area_wait_state_control[`AWSC_A5_HI:`AWSC_A5_LO]);
        is_burst_area = 1'b1;
      end
      3'd4: begin
        first_waits = waits3(area_wait_state_control[`AWSC_A4_HI:`AWSC_A4_LO]);
      end
      3'd3: begin
        if (ctrl[`AWSC_CTRL_A3_SDRAM]) begin
          cas_latency = cas2(area_wait_state_control[`AWSC_A3_HI:`AWSC_A3_LO]);
          first_waits = {2'b00, cas_latency};
        end else begin
          first_waits = {2'b00, area_wait_state_control[`AWSC_A3_HI:`AWSC_A3_LO]};
        end
      end
      3'd2: begin
        if (ctrl[`AWSC_CTRL_A2_SDRAM]) begin
          cas_latency = cas2(area_wait_state_control[`AWSC_A2_HI:`AWSC_A2_LO]);
          first_waits = {2'b00, cas_latency};
        end else begin
          first_waits = {2'b00, area_wait_state_control[`AWSC_A2_HI:`AWSC_A2_LO]};
        end
      end
      3'd0: begin
        first_waits   = waits3(area_wait_state_control[`AWSC_A0_HI:`AWSC_A0_LO]);
        is_burst_area = 1'b1;
      end
      default: begin
        first_waits = 4'd0;
      end
    endcase
    // SDRAM latency is fixed, so the wait pin plays no part there
    first_honour = (first_waits != 4'd0) && (cas_latency == 2'd0);
    if (is_burst_area) begin
      burst_load = 4'(pitch3(sel_area == 3'd6 ?
                   area_wait_state_control[`AWSC_A6_HI:`AWSC_A6_LO] :
                   sel_area == 3'd5 ?
                   area_wait_state_control[`AWSC_A5_HI:`AWSC_A5_LO] :
                   area_wait_state_control[`AWSC_A0_HI:`AWSC_A0_LO]) - 4'd1);
    end else begin
      burst_load = first_waits;
    end
  end

  // Wait engine
  assign acc_ready = (state == ST_IDLE) & ~standby;
  assign beat_done = beat_q;
  assign acc_done  = done_q;
  assign stall     = honour & wait_held;

  always_comb begin
    next_state      = state;
    next_cur_area   = cur_area;
    next_cnt        = cnt;
    next_beats_left = beats_left;
    next_honour     = honour;
    next_beat_q     = 1'b0;
    next_done_q     = 1'b0;
    case (state)
      ST_IDLE: begin
        if (acc_valid && acc_ready) begin
          next_state      = ST_FIRST;
          next_cur_area   = acc_area;
          next_cnt        = first_waits;
          next_honour     = first_honour;
          next_beats_left = acc_extra_beats;
        end
      end
      ST_FIRST, ST_BURST: begin
        if (cnt != 4'd0) begin
          next_cnt = cnt - 4'd1;
        end else if (!stall) begin
          next_beat_q = 1'b1;
          if (beats_left == 3'd0) begin
            next_done_q = 1'b1;
            next_state  = ST_IDLE;
          end else begin
            next_beats_left = beats_left - 3'd1;
            next_state      = ST_BURST;
            if (cur_area == 3'd6 || cur_area == 3'd5 || cur_area == 3'd0) begin
              next_cnt    = burst_load;
              next_honour = 1'b1;
            end else begin
              next_cnt    = first_waits;
              next_honour = first_honour;
            end
          end
        end
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state      <= ST_IDLE;
      cur_area   <= 3'd0;
      cnt        <= 4'd0;
      beats_left <= 3'd0;
      honour     <= 1'b0;
      beat_q     <= 1'b0;
      done_q     <= 1'b0;
    end else if (ce) begin
      if (!manual_rst_n || standby) begin
        state      <= ST_IDLE;
        cnt        <= 4'd0;
        beats_left <= 3'd0;
        honour     <= 1'b0;
        beat_q     <= 1'b0;
        done_q     <= 1'b0;
      end else begin
        state      <= next_state;
        cur_area   <= next_cur_area;
        cnt        <= next_cnt;
        beats_left <= next_beats_left;
        honour     <= next_honour;
        beat_q     <= next_beat_q;
        done_q     <= next_done_q;
      end
    end
  end

endmodule

`default_nettype wire

// *** bench/awsc_props.sv ***
// Port checks for the area wait block
`timescale 1ns/100ps
`default_nettype none
module awsc_props (
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        standby,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic        acc_valid,
  input wire logic        acc_ready,
  input wire logic        bus_clock_output,
  input wire logic        beat_done,
  input wire logic        acc_done
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  b_retire_a: assert property (
    s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("Write response not retired");
  r_retire_a: assert property (
    s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("Read data not retired");
  r_answer_a: assert property (
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("Read answer late");
  rdy_rise_a: assert property (
    $rose(aresetn) && !standby |-> acc_ready)
    else $error("Engine not idle after reset");
  stby_rdy_a: assert property (
    standby |-> !acc_ready)
    else $error("Request accepted in standby");
  stby_clk_a: assert property (
    standby [*2] |-> !bus_clock_output)
    else $error("Bus clock runs in standby");
  first_gap_a: assert property (
    acc_valid && acc_ready |=> !beat_done)
    else $error("Transfer ended too early");
  acc_bound_a: assert property (
    acc_valid && acc_ready |-> ##[1:80] beat_done)
    else $error("Transfer never ended");
  done_beat_a: assert property (
    acc_done |-> beat_done)
    else $error("Done without last transfer");
  cover property (acc_done);
  cover property (s_axi_bvalid && s_axi_bready && s_axi_bresp == 2'h2);
  cover property (standby && !acc_ready);
endmodule
`default_nettype wire

// *** bench/awsc_mem_model.sv ***
// Wait-request model of an external memory on a decoded area
`timescale 1ns/100ps
`default_nettype none
module awsc_mem_model (
  input  wire logic       aclk,
  input  wire logic       aresetn,
  input  wire logic       acc_valid,
  input  wire logic       acc_ready,
  input  wire logic [3:0] hold_len,
  input  wire logic       hold_now,
  output logic            wait_req_n
);
  logic [3:0] cnt;
  logic [3:0] next_cnt;
  always_comb begin
    next_cnt = cnt;
    if (acc_valid && acc_ready) next_cnt = hold_len;
    else if (cnt != 4'h0) next_cnt = cnt - 4'h1;
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) cnt <= 4'h0;
    else cnt <= next_cnt;
  end
  // Released line returns high
  assign wait_req_n = !(hold_now || cnt != 4'h0);
endmodule
`default_nettype wire

// *** bench/tb_awsc_top.sv ***
// Self-checking bench for the area wait block
`include "awsc_defines.svh"
`timescale 1ns/100ps
`default_nettype none
module tb_awsc_top;
  import awsc_pkg::*;
  logic aclk = 0, aresetn = 0, mrn = 1, stb = 0, awv = 0, wv = 0, br = 0;
  logic arv = 0, rr = 0, av = 0, hn = 0, ce = 1, bq;
  logic [11:0] awa = 0, ara = 0;
  logic [31:0] wd = 0, rd, d;
  logic [1:0]  rs;
  logic [2:0]  aa = 0, eb = 0;
  logic [3:0]  hl = 0;
  wire         awr, wr, bv, arr, rv, ard, bd, ad, wrn, bco;
  wire [1:0]   bre, rre, cas;
  wire [31:0]  rda;
  int err_total = 0, tests_run = 0, cyc = 0, t, p, seed = 32'h3b71;
  int fw[8] = '{0, 1, 2, 3, 4, 6, 8, 10};
  int fp[8] = '{2, 2, 3, 4, 4, 6, 8, 10};
  int lat[4] = '{1, 1, 2, 3};
  int lo[6] = '{13, 10, 7, 5, 3, 0};
  logic [2:0] an[6] = '{3'h6, 3'h5, 3'h4, 3'h3, 3'h2, 3'h0};
  always #4 aclk = ~aclk;
  awsc_top i_dut (.aclk(aclk), .aresetn(aresetn), .ce(ce), .manual_rst_n(mrn),
    .standby(stb), .s_axi_awaddr(awa), .s_axi_awprot(3'h0), .s_axi_awvalid(awv),
    .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(4'hf), .s_axi_wvalid(wv),
    .s_axi_wready(wr), .s_axi_bresp(bre), .s_axi_bvalid(bv), .s_axi_bready(br),
    .s_axi_araddr(ara), .s_axi_arprot(3'h0), .s_axi_arvalid(arv), .s_axi_arready(arr),
    .s_axi_rdata(rda), .s_axi_rresp(rre), .s_axi_rvalid(rv), .s_axi_rready(rr),
    .acc_valid(av), .acc_ready(ard), .acc_area(aa), .acc_extra_beats(eb),
    .wait_req_n(wrn), .bus_clock_output(bco), .beat_done(bd), .acc_done(ad),
    .cas_latency(cas));
  awsc_mem_model i_mem (.aclk(aclk), .aresetn(aresetn), .acc_valid(av), .acc_ready(ard),
    .hold_len(hl), .hold_now(hn), .wait_req_n(wrn));
  task automatic final_report;
    if (err_total == 0 && tests_run > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    tests_run++;
    if (g !== e) begin
      err_total++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic axw(input logic [11:0] a, input logic [31:0] x);
    logic ta, tw, h;
    ta = 0;
    tw = 0;
    h = 0;
    @(posedge aclk);
    awa <= a;
    wd <= x;
    awv <= 1;
    wv <= 1;
    br <= 1;
    while (!h) begin
      @(negedge aclk);
      ta = ta || awr === 1'b1;
      tw = tw || wr === 1'b1;
      h = bv === 1'b1;
      rs = bre;
      @(posedge aclk);
      if (ta) awv <= 0;
      if (tw) wv <= 0;
      if (h) br <= 0;
    end
  endtask
  task automatic axr(input logic [11:0] a);
    logic ta, h;
    ta = 0;
    h = 0;
    @(posedge aclk);
    ara <= a;
    arv <= 1;
    rr <= 1;
    while (!h) begin
      @(negedge aclk);
      ta = ta || arr === 1'b1;
      h = rv === 1'b1;
      rs = rre;
      rd = rda;
      @(posedge aclk);
      if (ta) arv <= 0;
      if (h) rr <= 0;
    end
  endtask
  task automatic acc(input logic [2:0] ar, input logic [2:0] n, output int ft, output int fq);
    @(posedge aclk);
    aa <= ar;
    eb <= n;
    av <= 1;
    do @(negedge aclk); while (ard !== 1'b1);
    @(posedge aclk);
    av <= 0;
    ft = -1;
    fq = 0;
    do begin
      @(negedge aclk);
      ft++;
    end while (bd !== 1'b1);
    if (n != 0) begin
      do begin
        @(negedge aclk);
        fq++;
      end while (bd !== 1'b1);
    end
    while (ad !== 1'b1) @(negedge aclk);
    @(posedge aclk);
  endtask
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      err_total++;
      final_report;
    end
  end
  initial begin
    repeat (8) @(posedge aclk);
    aresetn <= 1;
    axr(12'h000);
    chk(rd, 32'h0000_ffff);
    axr(12'h004);
    chk(rd, 32'h0000_0000);
    axr(12'h00c);
    chk(rs, `AWSC_RESP_SLVERR);
    axw(12'h010, 32'h0000_0000);
    chk(rs, `AWSC_RESP_SLVERR);
    ce <= 0;
    @(negedge aclk);
    bq = bco;
    @(negedge aclk);
    chk(bco, bq);
    @(posedge aclk);
    ce <= 1;
    @(negedge aclk);
    bq = bco;
    @(negedge aclk);
    chk(bco, !bq);
    for (int i = 0; i < 6; i++) begin
      for (int c = 0; c < ((i == 3 || i == 4) ? 4 : 8); c++) begin
        d = $random(seed);
        d[31:16] = 16'h0000;
        d[lo[i] +: 3] = c[2:0];
        axw(12'h000, d);
        axr(12'h000);
        chk(rd, d);
        acc(an[i], 3'((i < 2 || i == 5) ? 1 : 0), t, p);
        chk(t, fw[c] + 1);
        if (i < 2 || i == 5) chk(p, fp[c]);
      end
    end
    chk(cas, 32'h0000_0000);
    axw(12'h004, 32'h0000_0006);
    for (int c = 0; c < 4; c++) begin
      axw(12'h000, {16'h0000, 9'h000, c[1:0], c[1:0], 3'h0});
      for (int k = 2; k < 4; k++) begin
        @(posedge aclk);
        aa <= k[2:0];
        @(negedge aclk);
        chk(cas, lat[c]);
      end
      acc(3'h3, 3'h0, t, p);
      chk(t, lat[c] + 1);
    end
    axw(12'h004, 32'h0000_0000);
    axw(12'h000, 32'h0000_5a3c);
    mrn <= 0;
    stb <= 1;
    repeat (3) @(posedge aclk);
    @(negedge aclk);
    chk(bco, 1'b0);
    @(posedge aclk);
    mrn <= 1;
    stb <= 0;
    axr(12'h000);
    chk(rd, 32'h0000_5a3c);
    for (int s = 0; s < 2; s++) begin
      axw(12'h004, s);
      axw(12'h000, 32'h0000_0200);
      hl <= 4'h6;
      acc(3'h4, 3'h0, t, p);
      chk(t > 5 && t < 18, 1);
      hl <= 4'h0;
      axw(12'h000, 32'h0000_0000);
      hn <= 1;
      repeat (6) @(posedge aclk);
      acc(3'h4, 3'h0, t, p);
      hn <= 0;
      chk(t, 1);
    end
    aresetn <= 0;
    repeat (2) @(posedge aclk);
    aresetn <= 1;
    axr(12'h000);
    chk(rd, 32'h0000_ffff);
    final_report;
  end
endmodule
bind awsc_top awsc_props i_props (
  .aclk             (aclk),
  .aresetn          (aresetn),
  .standby          (standby),
  .s_axi_bvalid     (s_axi_bvalid),
  .s_axi_bready     (s_axi_bready),
  .s_axi_bresp      (s_axi_bresp),
  .s_axi_rvalid     (s_axi_rvalid),
  .s_axi_rready     (s_axi_rready),
  .s_axi_rdata      (s_axi_rdata),
  .s_axi_arvalid    (s_axi_arvalid),
  .s_axi_arready    (s_axi_arready),
  .acc_valid        (acc_valid),
  .acc_ready        (acc_ready),
  .bus_clock_output (bus_clock_output),
  .beat_done        (beat_done),
  .acc_done         (acc_done)
);
`default_nettype wire
